// ===== rtl/sdsc_core.sv
// sdsc_core: configuration registers and adaptive element shuffler
// assumes: register port and quantizer code on clk_sys_i, sync reset
`timescale 1ns/100ps
module sdsc_core
  import sdsc_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic signed [QCODE_W-1:0] qcode_i,
  output logic [N_ELEM-1:0] elem_sel_o,
  output logic shuffle_active_o,
  output sdsc_margin_s margin_o,
  output logic [DATA_W-1:0] fb_fs_code_o,
  output logic [FS_UA_W-1:0] fb_fs_ua_o
);

  // hold counter is 16 bits wide
  if (HOLD < 1 || HOLD > 65535) begin : g_hold_chk
    $error("sdsc_core: HOLD must be 1..65535");
  end

  localparam int unsigned HOLD_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD);

  // registers
  logic [DATA_W-1:0] lower_edge_margin_ff;
  logic [DATA_W-1:0] upper_edge_margin_ff;
  logic [DATA_W-1:0] center_resonator_offset_ff;
  logic [DATA_W-1:0] feedback_current_full_scale_ff;
  logic [DATA_W-1:0] shuffle_threshold_fast_rates_ff;
  logic [DATA_W-1:0] shuffle_threshold_slow_rates_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic rvalid_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lower_edge_margin_ff <= RST_LOWER_MARGIN;
      upper_edge_margin_ff <= RST_UPPER_MARGIN;
      center_resonator_offset_ff <= RST_CENTER_OFFSET;
      feedback_current_full_scale_ff <= RST_FB_FULL_SCALE;
      shuffle_threshold_fast_rates_ff <= RST_THR_FAST;
      shuffle_threshold_slow_rates_ff <= RST_THR_SLOW;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_LOWER_MARGIN) begin
        lower_edge_margin_ff <= reg_wdata_i;
      end else if (reg_addr_i == OFS_UPPER_MARGIN) begin
        upper_edge_margin_ff <= reg_wdata_i;
      end else if (reg_addr_i == OFS_CENTER_OFFSET) begin
        center_resonator_offset_ff <= reg_wdata_i;
      end else if (reg_addr_i == OFS_FB_FULL_SCALE) begin
        feedback_current_full_scale_ff <= reg_wdata_i;
      end else if (reg_addr_i == OFS_THR_FAST) begin
        shuffle_threshold_fast_rates_ff <= reg_wdata_i;
      end else if (reg_addr_i == OFS_THR_SLOW) begin
        shuffle_threshold_slow_rates_ff <= reg_wdata_i;
      end
    end
  end

  // read port, one cycle latency, unmapped reads zero
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    if (reg_addr_i == OFS_LOWER_MARGIN) begin
      nxt_rdata = lower_edge_margin_ff;
    end else if (reg_addr_i == OFS_UPPER_MARGIN) begin
      nxt_rdata = upper_edge_margin_ff;
    end else if (reg_addr_i == OFS_CENTER_OFFSET) begin
      nxt_rdata = center_resonator_offset_ff;
    end else if (reg_addr_i == OFS_FB_FULL_SCALE) begin
      nxt_rdata = feedback_current_full_scale_ff;
    end else if (reg_addr_i == OFS_THR_FAST) begin
      nxt_rdata = shuffle_threshold_fast_rates_ff;
    end else if (reg_addr_i == OFS_THR_SLOW) begin
      nxt_rdata = shuffle_threshold_slow_rates_ff;
    end else begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign margin_o = '{lower: lower_edge_margin_ff,
                      upper: upper_edge_margin_ff,
                      center: center_resonator_offset_ff};
  assign fb_fs_code_o = feedback_current_full_scale_ff;

  // full-scale current in microamps, code taken as unsigned
  logic [FS_UA_W-1:0] fs_ua_ff;
  logic [23:0] fs_prod;

  always_comb begin
    fs_prod = 24'(FS_MAX_UA) * 24'(feedback_current_full_scale_ff);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fs_ua_ff <= '0;
    end else begin
      fs_ua_ff <= FS_UA_W'(fs_prod / 24'(FS_CODE_DIV));
    end
  end

  assign fb_fs_ua_o = fs_ua_ff;

  // pick rate and threshold from the first nibble not 0xF
  function automatic sdsc_shuf_cfg_s decode_cfg(
    input logic [DATA_W-1:0] fast,
    input logic [DATA_W-1:0] slow
  );
    sdsc_shuf_cfg_s c;
    c.rate = RATE_OFF;
    c.thr = THR_OFF;
    if (fast[NIB_LO +: 4] != THR_OFF) begin
      c.rate = RATE_DIV1;
      c.thr = fast[NIB_LO +: 4];
    end else if (fast[NIB_HI +: 4] != THR_OFF) begin
      c.rate = RATE_DIV2;
      c.thr = fast[NIB_HI +: 4];
    end else if (slow[NIB_LO +: 4] != THR_OFF) begin
      c.rate = RATE_DIV3;
      c.thr = slow[NIB_LO +: 4];
    end else if (slow[NIB_HI +: 4] != THR_OFF) begin
      c.rate = RATE_DIV4;
      c.thr = slow[NIB_HI +: 4];
    end
    return c;
  endfunction : decode_cfg

  sdsc_shuf_cfg_s cfg;

  always_comb begin
    cfg = decode_cfg(shuffle_threshold_fast_rates_ff,
                     shuffle_threshold_slow_rates_ff);
  end

  // rate divider: one-cycle enable every 1..4 clocks
  logic [1:0] div_ff;
  logic [1:0] div_last;
  logic rate_tick;

  always_comb begin
    case (cfg.rate)
      RATE_DIV2: div_last = 2'd1;
      RATE_DIV3: div_last = 2'd2;
      RATE_DIV4: div_last = 2'd3;
      default: div_last = 2'd0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      div_ff <= '0;
    end else if (div_ff >= div_last) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 2'd1;
    end
  end

  assign rate_tick = (cfg.rate != RATE_OFF) && (div_ff >= div_last);

  // quantizer magnitude, clamped to 8
  logic [QCODE_W-1:0] qabs;
  logic [3:0] qmag;
  logic trigger;

  always_comb begin
    qabs = qcode_i[QCODE_W-1] ? QCODE_W'(-qcode_i) : qcode_i;
    qmag = (qabs > QCODE_W'(QMAG_MAX)) ? QMAG_MAX : qabs[3:0];
  end

  // compared every clock
  always_comb begin
    if (cfg.rate == RATE_OFF) begin
      trigger = 1'b0;
    end else if (cfg.thr == THR_ALWAYS) begin
      trigger = 1'b1;
    end else begin
      trigger = (qmag >= cfg.thr);
    end
  end

  // hold counter keeps shuffling after signal drops
  logic [HOLD_W-1:0] hold_ff;
  logic active;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hold_ff <= '0;
    end else if (trigger) begin
      hold_ff <= HOLD_LOAD;
    end else if (hold_ff != '0) begin
      hold_ff <= hold_ff - HOLD_W'(1);
    end
  end

  assign active = trigger || (hold_ff != '0);

  logic active_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= active;
    end
  end

  assign shuffle_active_o = active_ff;

  // pseudorandom rotation source
  logic [15:0] rnd;
  logic step;

  assign step = active && rate_tick;

  sdsc_lfsr #(
    .WIDTH(16)
  ) u_lfsr (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .step_i(step),
    .value_o(rnd)
  );

  logic [ROT_W-1:0] rot_ff;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rot_ff <= '0;
    end else if (!active) begin
      rot_ff <= '0;
    end else if (rate_tick) begin
      rot_ff <= rnd[ROT_W-1:0];
    end
  end

  // thermometer of unit elements rotated by the current offset
  function automatic logic [N_ELEM-1:0] rotl(
    input logic [N_ELEM-1:0] v,
    input logic [ROT_W-1:0] r
  );
    logic [2*N_ELEM-1:0] d;
    d = {v, v} << r;
    return d[2*N_ELEM-1 -: N_ELEM];
  endfunction : rotl

  logic [QCODE_W-1:0] level;
  logic [N_ELEM:0] therm;
  logic [N_ELEM-1:0] elem_ff;

  always_comb begin
    level = qcode_i + QCODE_OFS;
    if (qcode_i[QCODE_W-1] && qabs > QCODE_W'(QMAG_MAX)) begin
      level = '0;
    end else if (!qcode_i[QCODE_W-1] && qabs > QCODE_W'(QMAG_MAX)) begin
      level = QCODE_W'(N_ELEM);
    end
    therm = (N_ELEM+1)'((17'h1 << level) - 17'h1);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      elem_ff <= '0;
    end else begin
      elem_ff <= rotl(therm[N_ELEM-1:0], active ? rot_ff : '0);
    end
  end

  assign elem_sel_o = elem_ff;

endmodule : sdsc_core

// ===== rtl/sdsc_lfsr.sv
// sdsc_lfsr: galois lfsr giving pseudorandom rotation values
// assumes: same clock and synchronous reset as the parent
`timescale 1ns/100ps
module sdsc_lfsr #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] TAPS = 16'hb400,
  parameter logic [15:0] SEED = 16'hace1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic step_i,
  output logic [WIDTH-1:0] value_o
);

  // refuse widths the tap mask cannot serve
  if (WIDTH != 16) begin : g_width_chk
    $error("sdsc_lfsr: WIDTH must be 16");
  end

  logic [WIDTH-1:0] state_ff;
  logic [WIDTH-1:0] nxt_state;

  always_comb begin
    nxt_state = {1'b0, state_ff[WIDTH-1:1]};
    if (state_ff[0]) begin
      nxt_state = nxt_state ^ TAPS;
    end
  end

  // advances only when stepped
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= SEED;
    end else if (step_i) begin
      state_ff <= nxt_state;
    end
  end

  assign value_o = state_ff;

endmodule : sdsc_lfsr

// ===== rtl/sdsc_pkg.sv
// sdsc_pkg: constants and types for the sigma-delta config/shuffler block
// assumes: 10-bit register addresses, 8-bit register data
package sdsc_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_LOWER_MARGIN = 10'h107;
  localparam logic [ADDR_W-1:0] OFS_UPPER_MARGIN = 10'h108;
  localparam logic [ADDR_W-1:0] OFS_CENTER_OFFSET = 10'h109;
  localparam logic [ADDR_W-1:0] OFS_FB_FULL_SCALE = 10'h10a;
  localparam logic [ADDR_W-1:0] OFS_THR_FAST = 10'h342;
  localparam logic [ADDR_W-1:0] OFS_THR_SLOW = 10'h343;

  // reset values
  localparam logic [DATA_W-1:0] RST_LOWER_MARGIN = 8'h05;
  localparam logic [DATA_W-1:0] RST_UPPER_MARGIN = 8'h05;
  localparam logic [DATA_W-1:0] RST_CENTER_OFFSET = 8'h00;
  localparam logic [DATA_W-1:0] RST_FB_FULL_SCALE = 8'h40;
  localparam logic [DATA_W-1:0] RST_THR_FAST = 8'hf5;
  localparam logic [DATA_W-1:0] RST_THR_SLOW = 8'hff;

  // threshold nibble fields
  localparam int unsigned NIB_LO = 0;
  localparam int unsigned NIB_HI = 4;
  localparam logic [3:0] THR_OFF = 4'hf;
  localparam logic [3:0] THR_ALWAYS = 4'h0;
  localparam logic [3:0] QMAG_MAX = 4'h8;

  // feedback current: 4 mA times code over 64, in microamps
  localparam int unsigned FS_MAX_UA = 4000;
  localparam int unsigned FS_CODE_DIV = 64;
  localparam int unsigned FS_UA_W = 14;

  // quantizer and elements
  localparam int unsigned QCODE_W = 5;
  localparam int unsigned N_ELEM = 16;
  localparam int unsigned ROT_W = 4;
  localparam logic [QCODE_W-1:0] QCODE_OFS = 5'h08;

  // shuffler hold time after falling below threshold, in clocks
  localparam int unsigned HOLD_CYCLES = 16;

  typedef enum logic [2:0] {
    RATE_OFF,
    RATE_DIV1,
    RATE_DIV2,
    RATE_DIV3,
    RATE_DIV4
  } sdsc_rate_e;

  typedef struct packed {
    logic [DATA_W-1:0] lower;
    logic [DATA_W-1:0] upper;
    logic [DATA_W-1:0] center;
  } sdsc_margin_s;

  typedef struct packed {
    sdsc_rate_e rate;
    logic [3:0] thr;
  } sdsc_shuf_cfg_s;

endpackage : sdsc_pkg

// ===== sim/sdsc_core_assertions.sv
// sdsc_core_assertions: port-level checks of sdsc_core
// assumes: bound to sdsc_core, one clock, sync active-high reset
`timescale 1ns/100ps
module sdsc_core_assertions
  import sdsc_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic signed [QCODE_W-1:0] qcode_i,
  input wire logic [N_ELEM-1:0] elem_sel_o,
  input wire logic shuffle_active_o,
  input wire sdsc_margin_s margin_o,
  input wire logic [DATA_W-1:0] fb_fs_code_o,
  input wire logic [FS_UA_W-1:0] fb_fs_ua_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // consecutive active cycles
  logic [7:0] run_ff;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !shuffle_active_o) begin
      run_ff <= 8'h00;
    end else if (run_ff != 8'hff) begin
      run_ff <= run_ff + 8'h01;
    end
  end
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  a_rd_only: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  a_rdata_hold: assert property (
    !reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
  a_fs_write: assert property (
    reg_wr_i && reg_addr_i == OFS_FB_FULL_SCALE
    |=> fb_fs_code_o == $past(reg_wdata_i))
    else $error("full-scale code not written");
  a_margin_write: assert property (
    reg_wr_i && reg_addr_i == OFS_LOWER_MARGIN
    |=> margin_o.lower == $past(reg_wdata_i))
    else $error("lower margin not written");
  a_fs_scale: assert property (
    !$past(sys_rst_i) |-> fb_fs_ua_o ==
    FS_UA_W'(FS_MAX_UA * $past(fb_fs_code_o) / FS_CODE_DIV))
    else $error("full-scale current wrong");
  a_elem_count: assert property (
    !$past(sys_rst_i) && $past(qcode_i) inside {[-8:8]}
    |-> $countones(elem_sel_o) == $past(qcode_i) + 8)
    else $error("element count wrong");
  a_fixed_map: assert property (
    !shuffle_active_o && !$past(sys_rst_i) &&
    $past(qcode_i) inside {[-8:8]} |-> elem_sel_o ==
    N_ELEM'((17'h1 << ($past(qcode_i) + 8)) - 17'h1))
    else $error("inactive mapping not fixed");
  a_hold_min: assert property (
    $fell(shuffle_active_o) |-> run_ff >= HOLD)
    else $error("shuffler dropped too early");
endmodule : sdsc_core_assertions

// ===== sim/tb_sigma_delta_shuffler_config.sv
// tb_sigma_delta_shuffler_config: register and shuffler tests of sdsc_core
// assumes: sdsc_pkg, sdsc_core and its checker compiled before
`timescale 1ns/100ps
module tb_sigma_delta_shuffler_config;
  import sdsc_pkg::*;
  localparam int unsigned HOLD_T = 4;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic reg_wr_i = 1'b0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_rd_i = 1'b0;
  logic signed [QCODE_W-1:0] qcode_i = '0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [N_ELEM-1:0] elem_sel_o;
  logic shuffle_active_o;
  sdsc_margin_s margin_o;
  logic [DATA_W-1:0] fb_fs_code_o;
  logic [FS_UA_W-1:0] fb_fs_ua_o;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [ADDR_W-1:0] ofs_t [6] = '{OFS_LOWER_MARGIN, OFS_UPPER_MARGIN,
    OFS_CENTER_OFFSET, OFS_FB_FULL_SCALE, OFS_THR_FAST, OFS_THR_SLOW};
  logic [DATA_W-1:0] rst_t [6] = '{8'h05, 8'h05, 8'h00, 8'h40, 8'hf5, 8'hff};
  logic [DATA_W-1:0] wv_t [4] = '{8'h08, 8'h10, 8'h02, 8'h10};
  logic [DATA_W-1:0] rf_t [4] = '{8'hf0, 8'h0f, 8'hff, 8'hff};
  logic [DATA_W-1:0] rs_t [4] = '{8'hff, 8'hff, 8'hf0, 8'h0f};
  always #2 clk_sys_i = ~clk_sys_i;
  sdsc_core #(.HOLD(HOLD_T)) sdsc_core_i (.clk_sys_i, .sys_rst_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .qcode_i, .elem_sel_o, .shuffle_active_o, .margin_o,
    .fb_fs_code_o, .fb_fs_ua_o);
  task automatic chk_v(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v
  task automatic give_verdict();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_v("rvalid", 24'h1, reg_rvalid_o);
    chk_v("rdata", e, reg_rdata_o);
  endtask : rd
  task automatic q(input int v, input int n);
    @(posedge clk_sys_i);
    qcode_i <= QCODE_W'(v);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : q
  initial begin
    int gap;
    int mingap;
    int ch;
    logic [N_ELEM-1:0] prev;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ofs_t[i], rst_t[i]);
    end
    chk_v("fs_ua", 24'h0fa0, fb_fs_ua_o);
    rd(10'h100, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ofs_t[i], wv_t[i]);
      rd(ofs_t[i], wv_t[i]);
    end
    chk_v("margin", 24'h081002, margin_o);
    chk_v("fs_ua", 24'h03e8, fb_fs_ua_o);
    chk_v("fs_code", 24'h10, fb_fs_code_o);
    q(4, 2);
    chk_v("active", 24'h0, shuffle_active_o);
    chk_v("elem", 24'h000fff, elem_sel_o);
    q(5, 1);
    chk_v("active", 24'h1, shuffle_active_o);
    q(-5, 1);
    chk_v("active", 24'h1, shuffle_active_o);
    q(0, HOLD_T - 1);
    chk_v("active", 24'h1, shuffle_active_o);
    q(0, 3);
    chk_v("active", 24'h0, shuffle_active_o);
    chk_v("elem", 24'h0000ff, elem_sel_o);
    for (int r = 0; r < 4; r++) begin
      wr(OFS_THR_FAST, rf_t[r]);
      wr(OFS_THR_SLOW, rs_t[r]);
      q(0, 2);
      chk_v("active", 24'h1, shuffle_active_o);
      gap = 0;
      mingap = 99;
      ch = 0;
      prev = elem_sel_o;
      repeat (24) begin
        @(posedge clk_sys_i);
        #1;
        gap++;
        if (elem_sel_o !== prev) begin
          if (ch > 0 && gap < mingap) mingap = gap;
          ch++;
          gap = 0;
          prev = elem_sel_o;
        end
        chk_v("count", 24'd8, $countones(elem_sel_o));
      end
      chk_v("gap", 24'h1, mingap >= r + 1);
      chk_v("changes", 24'h1, ch > 2 && ch <= 24 / (r + 1) + 1);
    end
    wr(OFS_THR_FAST, 8'hf8);
    wr(OFS_THR_SLOW, 8'hff);
    q(0, HOLD_T + 2);
    q(7, 2);
    chk_v("active", 24'h0, shuffle_active_o);
    q(8, 1);
    chk_v("active", 24'h1, shuffle_active_o);
    wr(OFS_THR_FAST, 8'hff);
    wr(OFS_THR_SLOW, 8'hf3);
    q(0, HOLD_T + 2);
    q(-3, 1);
    chk_v("active", 24'h1, shuffle_active_o);
    wr(OFS_THR_SLOW, 8'hff);
    q(0, HOLD_T + 2);
    q(-8, 3);
    chk_v("active", 24'h0, shuffle_active_o);
    chk_v("elem", 24'h0, elem_sel_o);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(OFS_THR_FAST, 8'hf5);
    give_verdict();
  end
endmodule : tb_sigma_delta_shuffler_config
bind sdsc_core sdsc_core_assertions #(.HOLD(HOLD)) sdsc_core_assertions_i (
  .clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
  .reg_rdata_o, .reg_rvalid_o, .qcode_i, .elem_sel_o, .shuffle_active_o,
  .margin_o, .fb_fs_code_o, .fb_fs_ua_o);
